/* design/meiu_pkg.sv */
// Package of constants and carrier types for the meter event interrupt unit.
package meiu_pkg;

  // Register select codes on the internal register port.
  localparam logic [1:0] MEIU_SEL_MASK_A   = 2'h0;
  localparam logic [1:0] MEIU_SEL_MASK_B   = 2'h1;
  localparam logic [1:0] MEIU_SEL_STATUS_A = 2'h2;
  localparam logic [1:0] MEIU_SEL_STATUS_B = 2'h3;

  // Reset values.
  localparam logic [31:0] MEIU_MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] MEIU_STATUS_RESET = 32'h0000_0000;

  // Flag positions in the second status word.
  localparam int MEIU_B_TOTAL_IDLE  = 0;
  localparam int MEIU_B_FUND_IDLE   = 1;
  localparam int MEIU_B_APP_IDLE    = 2;
  localparam int MEIU_B_RESET_DONE  = 15;
  localparam int MEIU_B_DIP         = 16;
  localparam int MEIU_B_OVERCURRENT = 17;
  localparam int MEIU_B_OVERVOLTAGE = 18;
  localparam int MEIU_B_CUR_PEAK    = 23;
  localparam int MEIU_B_VOLT_PEAK   = 24;

  // Implemented flag bits; all others are reserved and read zero.
  localparam logic [31:0] MEIU_STATUS_A_IMPL = 32'h0007_ffff;
  localparam logic [31:0] MEIU_STATUS_B_IMPL = 32'h01ff_ffff;

  // Bits of the first word that carry a paired phase sign indication.
  localparam logic [31:0] MEIU_A_SIGN_PAIRED = 32'h0004_3fc0;
  // Bits of the second word that carry paired per-phase indications.
  localparam logic [31:0] MEIU_B_PHASE_PAIRED = 32'h0187_0007;

  // Field positions in the per-phase idle register.
  localparam int MEIU_IDLE_TOTAL_LSB = 0;
  localparam int MEIU_IDLE_FUND_LSB  = 3;
  localparam int MEIU_IDLE_APP_LSB   = 6;

  // Register access from the serial port decoder.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  sel;
    logic [31:0] wdata;
  } meiu_reg_req_t;

  // Per-phase no-load indications, one three-bit field per kind.
  typedef struct packed {
    logic [2:0] apparent;
    logic [2:0] fundamental;
    logic [2:0] total;
  } meiu_idle_phase_t;

endpackage

/* design/meiu_flag_word.sv */
// One sticky write-one-to-clear flag word with its masked request term.
`timescale 1ns/1ps
`default_nettype none
module meiu_flag_word
  import meiu_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] impl_bits,
  input  wire logic [31:0] set_bits,
  input  wire logic        clr_en,
  input  wire logic [31:0] clr_bits,
  input  wire logic [31:0] mask,
  output var  logic [31:0] flags_reg,
  output var  logic        req_next
);

  logic [31:0] flags_next;

  // Clears first, then sets, so a coincident event survives.
  always_comb begin
    flags_next = flags_reg;
    if (clr_en) begin
      flags_next = flags_next & ~clr_bits;
    end
    flags_next = (flags_next | set_bits) & impl_bits;
  end

  // Flags latch whatever the mask says.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= MEIU_STATUS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Request from the next flag value so the top pin flop has no extra lag.
  assign req_next = |(flags_next & mask);

endmodule
`default_nettype wire

/* design/meiu_top.sv */
// Top of the meter event interrupt unit: masks, flag words and pins.
//
// Summary of operation
// - Two active-low request lines, each gated by its own 32-bit mask.
// - Mask bit one enables its source; zero keeps it off the line.
// - Events set their flag regardless of the mask.
// - A line goes low while any flag and same mask bit are both one.
// - Writing a status word clears flags written one, keeps others.
// - A line stays low until all enabled causing flags are cleared.
// - All mask bits are zero after reset.
// - Reset completion sets reset-done flag, bit 15, unmaskable on line b.
// - Word b bits 0 to 2 pair with the per-phase idle register.
// - Word b bits 16 to 18 pair with the phase condition register.
// - Word b bits 23, 24 pair with current and voltage peak records.
// - Word a reversal bits 6 to 13 and 18 pair with phase sign.
// - Idle register holds three phase fields updated with their flags.
//
// Register port: one request per cycle on reg_req, and the select codes of
// the package pick the word. A write lands at the edge that takes it. A read
// returns its word on reg_rdata_reg at that same edge, and that value stands
// until the next read, so the host may sample it at leisure.
//
// Both request lines are flops fed from the next flag value rather than the
// present one; this saves a cycle of latency between an event and its line.
//
// Limitation: the paired per-phase condition, sign and peak registers sit
// outside this unit. The paired_pending_reg output only shows which set
// flags have such a register behind them, and it folds the two words into
// one, so bit 18 of either word lands on the same position there.
//
// Reset: masks and flags clear and both lines go high. Reset-done is not
// raised here; the block that sequences reset pulses reset_seq_done once it
// is over, and that pulse sets the flag like any other event.
//
// An event and a clear of the same flag in one cycle leave the flag set:
// losing the event would be worse than servicing it twice.
`timescale 1ns/1ps
`default_nettype none
module meiu_top
  import meiu_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire meiu_reg_req_t    reg_req,
  output var  logic [31:0]      reg_rdata_reg,
  input  wire logic             reset_seq_done,
  input  wire logic [31:0]      event_a,
  input  wire logic [31:0]      event_b,
  input  wire meiu_idle_phase_t idle_phase_in,
  output var  meiu_idle_phase_t per_phase_idle_state_reg,
  output var  logic [31:0]      paired_pending_reg,
  output var  logic             request_line_a_n_reg,
  output var  logic             request_line_b_n_reg
);

  // Stored masks, flag words and decode strobes.
  logic [31:0] irq_enable_mask_a_reg;
  logic [31:0] irq_enable_mask_b_reg;
  logic [31:0] event_flag_word_a;
  logic [31:0] event_flag_word_b;
  logic [31:0] set_b;
  logic [31:0] mask_b_eff;
  logic        req_a_next;
  logic        req_b_next;
  logic        wr_mask_a;
  logic        wr_mask_b;
  logic        wr_stat_a;
  logic        wr_stat_b;
  logic [31:0] rdata_next;
  logic [31:0] paired_a;
  logic [31:0] paired_b;

  // Decode one register select against one select code.
  function automatic logic sel_hit(input logic [1:0] sel,
                                   input logic [1:0] code);
    sel_hit = (sel == code);
  endfunction

  // Keep the bits of a word that a constant selects.
  function automatic logic [31:0] keep_bits(input logic [31:0] word,
                                            input logic [31:0] pick);
    keep_bits = word & pick;
  endfunction

  // Write strobes, one for each register word.
  assign wr_mask_a = reg_req.wr && sel_hit(reg_req.sel, MEIU_SEL_MASK_A);
  assign wr_mask_b = reg_req.wr && sel_hit(reg_req.sel, MEIU_SEL_MASK_B);
  assign wr_stat_a = reg_req.wr && sel_hit(reg_req.sel, MEIU_SEL_STATUS_A);
  assign wr_stat_b = reg_req.wr && sel_hit(reg_req.sel, MEIU_SEL_STATUS_B);

  // Mask registers; every source but reset-done is disabled out of reset.
  // A new mask reaches the lines one edge after the write lands.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_enable_mask_a_reg <= MEIU_MASK_RESET;
      irq_enable_mask_b_reg <= MEIU_MASK_RESET;
    end else begin
      if (wr_mask_a) begin
        irq_enable_mask_a_reg <= reg_req.wdata;
      end
      if (wr_mask_b) begin
        irq_enable_mask_b_reg <= reg_req.wdata;
      end
    end
  end

  // Reset-done is forced on in the effective mask, so the stored bit is inert.
  always_comb begin
    mask_b_eff = irq_enable_mask_b_reg;
    mask_b_eff[MEIU_B_RESET_DONE] = 1'b1;
  end

  // Only reset completion may set reset-done; a stray event bit is dropped
  // so that nothing but a real reset sequence can pull line b for it.
  always_comb begin
    set_b = event_b;
    set_b[MEIU_B_RESET_DONE] = reset_seq_done;
  end

  // First flag word; its request term drives line a. Reserved bits are cut
  // by impl_bits, so they read zero and ignore writes.
  meiu_flag_word u_word_a (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .impl_bits (MEIU_STATUS_A_IMPL),
    .set_bits  (event_a),
    .clr_en    (wr_stat_a),
    .clr_bits  (reg_req.wdata),
    .mask      (irq_enable_mask_a_reg),
    .flags_reg (event_flag_word_a),
    .req_next  (req_a_next)
  );

  // Second flag word; reset-done is always enabled onto line b through the
  // effective mask, whatever the stored mask bit says.
  meiu_flag_word u_word_b (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .impl_bits (MEIU_STATUS_B_IMPL),
    .set_bits  (set_b),
    .clr_en    (wr_stat_b),
    .clr_bits  (reg_req.wdata),
    .mask      (mask_b_eff),
    .flags_reg (event_flag_word_b),
    .req_next  (req_b_next)
  );

  // Active-low pins from flops; they rise only once no enabled flag is left.
  // Only a status write lowers the next flags; a mask write can also free them.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      request_line_a_n_reg <= 1'b1;
      request_line_b_n_reg <= 1'b1;
    end else begin
      request_line_a_n_reg <= ~req_a_next;
      request_line_b_n_reg <= ~req_b_next;
    end
  end

  // Idle phase fields load in the same cycle as their flag event, so a
  // read right after the status word shows the phases behind it.
  // A field keeps its phases until its own flag event fires again.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_phase_idle_state_reg <= '0;
    end else begin
      if (event_b[MEIU_B_TOTAL_IDLE]) begin
        per_phase_idle_state_reg.total <= idle_phase_in.total;
      end
      if (event_b[MEIU_B_FUND_IDLE]) begin
        per_phase_idle_state_reg.fundamental <=
          idle_phase_in.fundamental;
      end
      if (event_b[MEIU_B_APP_IDLE]) begin
        per_phase_idle_state_reg.apparent <=
          idle_phase_in.apparent;
      end
    end
  end

  // Set flags with a paired per-phase register behind them, per word.
  always_comb begin
    paired_a = keep_bits(event_flag_word_a,
                         MEIU_A_SIGN_PAIRED);
    paired_b = keep_bits(event_flag_word_b,
                         MEIU_B_PHASE_PAIRED);
  end

  // Word a sign pairs and word b phase pairs share one output word, so the
  // host still has to read both status words to tell them apart.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      paired_pending_reg <= '0;
    end else begin
      paired_pending_reg <= paired_a | paired_b;
    end
  end

  // Select the word a read returns; reserved flag bits are already zero.
  always_comb begin
    case (reg_req.sel)
      MEIU_SEL_MASK_A:   rdata_next = irq_enable_mask_a_reg;
      MEIU_SEL_MASK_B:   rdata_next = irq_enable_mask_b_reg;
      MEIU_SEL_STATUS_A: rdata_next = event_flag_word_a;
      MEIU_SEL_STATUS_B: rdata_next = event_flag_word_b;
      default:           rdata_next = '0;
    endcase
  end

  // Read data is held between reads, so a slow host may sample it late.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_reg <= '0;
    end else if (reg_req.rd) begin
      reg_rdata_reg <= rdata_next;
    end
  end

endmodule
`default_nettype wire

/* sim/meiu_checker.sv */
// Port assertions for the meter event interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module meiu_checker
  import meiu_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rst,
  input wire meiu_reg_req_t reg_req,
  input wire logic [31:0]   reg_rdata_reg,
  input wire logic          reset_seq_done,
  input wire logic [31:0]   event_a,
  input wire logic          request_line_a_n_reg,
  input wire logic          request_line_b_n_reg
);
  logic [31:0] ma_reg;
  logic        la;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign la = request_line_a_n_reg;
  // Shadow of the first mask, since line a can only be judged against it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ma_reg <= '0;
    end else if (reg_req.wr && reg_req.sel == MEIU_SEL_MASK_A) begin
      ma_reg <= reg_req.wdata;
    end
  end
  a_reset_high: assert property (
    $past(rst) |-> la && request_line_b_n_reg) else $error("line low");
  a_done_low: assert property (
    reset_seq_done |=> !request_line_b_n_reg) else $error("no done");
  a_event_low: assert property (
    |(event_a & ma_reg & MEIU_STATUS_A_IMPL) && !reg_req.wr |=> !la)
    else $error("no request");
  a_mask_off: assert property (
    ma_reg == 0 && $past(ma_reg) == 0 |-> la) else $error("masked low");
  a_clear_all: assert property (
    reg_req.wr && reg_req.sel == MEIU_SEL_STATUS_A && &reg_req.wdata
    && event_a == 0 |=> la) else $error("not cleared");
  a_resv_zero: assert property (
    reg_req.rd && reg_req.sel == MEIU_SEL_STATUS_A
    |=> reg_rdata_reg[31:19] == 0) else $error("reserved set");
  a_read_mask: assert property (
    reg_req.rd && reg_req.sel == MEIU_SEL_MASK_A
    |=> reg_rdata_reg == $past(ma_reg)) else $error("mask read");
  a_hold_low: assert property (
    !la && !reg_req.wr |=> !la) else $error("line rose");
  cover property (reset_seq_done);
  cover property ($fell(la));
  cover property (reg_req.wr && reg_req.sel == MEIU_SEL_STATUS_B);
endmodule
bind meiu_top meiu_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_req(reg_req), .reg_rdata_reg(reg_rdata_reg),
  .reset_seq_done(reset_seq_done), .event_a(event_a),
  .request_line_a_n_reg(request_line_a_n_reg),
  .request_line_b_n_reg(request_line_b_n_reg));
`default_nettype wire

/* sim/meiu_host_model.sv */
// Host model that services a falling request line as firmware would.
`timescale 1ns/1ps
`default_nettype none
module meiu_host_model
  import meiu_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          enable,
  input  wire logic          line_a_n,
  input  wire logic          line_b_n,
  input  wire logic [31:0]   rdata,
  output var  meiu_reg_req_t host_req,
  output var  logic          busy
);
  logic [1:0] step_reg;
  logic [1:0] sel_reg;
  logic [1:0] pick;
  logic       a_old_reg;
  logic       b_old_reg;
  assign busy = step_reg != 2'h0;
  assign pick = (b_old_reg && !line_b_n) ? MEIU_SEL_STATUS_B
                                         : MEIU_SEL_STATUS_A;
  // Read the word on a falling line, then write the same value back.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_reg <= 2'h0;
      sel_reg <= 2'h0;
      a_old_reg <= 1'b1;
      b_old_reg <= 1'b1;
      host_req <= '0;
    end else begin
      a_old_reg <= line_a_n;
      b_old_reg <= line_b_n;
      host_req <= '0;
      step_reg <= busy ? step_reg + 2'h1 : 2'h0;
      if (!busy && enable
          && ((a_old_reg && !line_a_n) || (b_old_reg && !line_b_n))) begin
        sel_reg <= pick;
        host_req <= '{1'b0, 1'b1, pick, 32'h0};
        step_reg <= 2'h1;
      end
      // The write goes out only once the read data has been seen.
      if (step_reg == 2'h2)
        host_req <= '{1'b1, 1'b0, sel_reg, rdata};
    end
  end
endmodule
`default_nettype wire

/* sim/meiu_top_test.sv */
// Randomised self-checking bench for the meter event interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module meiu_top_test
  import meiu_pkg::*;
;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             done_p = 1'b0;
  logic             host_en = 1'b0;
  logic [31:0]      ev_a = '0;
  logic [31:0]      ev_b = '0;
  meiu_idle_phase_t idle_in = '0;
  meiu_reg_req_t    tb_req = '0;
  meiu_reg_req_t    host_req;
  meiu_idle_phase_t idle_q;
  logic [31:0]      rdata;
  logic [31:0]      pend;
  logic             busy;
  logic             ln_a;
  logic             ln_b;
  logic [15:0]      lfsr = 16'ha9bf;
  int               failures = 0;
  int               comparisons = 0;
  int               cycles = 0;
  // Free-running 250 MHz clock.
  always #2 sys_clk = ~sys_clk;
  meiu_top DUT (.sys_clk(sys_clk), .rst(rst),
    .reg_req(busy ? host_req : tb_req), .reg_rdata_reg(rdata),
    .reset_seq_done(done_p), .event_a(ev_a), .event_b(ev_b),
    .idle_phase_in(idle_in), .per_phase_idle_state_reg(idle_q),
    .paired_pending_reg(pend), .request_line_a_n_reg(ln_a),
    .request_line_b_n_reg(ln_b));
  meiu_host_model host (.sys_clk(sys_clk), .rst(rst), .enable(host_en),
    .line_a_n(ln_a), .line_b_n(ln_b), .rdata(rdata),
    .host_req(host_req), .busy(busy));
  function automatic logic [31:0] rnd();
    repeat (32) lfsr = {lfsr[14:0],
                        lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr, ~lfsr};
  endfunction
  function automatic logic want(input logic [31:0] f, input logic [31:0] m);
    return !(|(f & m));
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic w, input logic [1:0] s, input logic [31:0] d);
    tb_req <= '{w, !w, s, d};
    @(posedge sys_clk);
    tb_req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic fire(input logic [31:0] a, input logic [31:0] b);
    ev_a <= a;
    ev_b <= b;
    @(posedge sys_clk);
    ev_a <= '0;
    ev_b <= '0;
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  // Main sequence: reset, reset-done, random masks and events, host service.
  initial begin
    logic [31:0] m;
    logic [31:0] x;
    logic        w;
    logic [31:0] mk [2];
    logic [31:0] pm;
    mk = '{32'h0, 32'h0};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({ln_a, ln_b}, 2'h3);
    done_p <= 1'b1;
    @(posedge sys_clk);
    done_p <= 1'b0;
    @(posedge sys_clk);
    chk(ln_b, 1'b0);
    go(1'b1, MEIU_SEL_STATUS_B, 32'h0000_8000);
    chk(ln_b, 1'b1);
    for (int i = 0; i < 14; i++) begin
      w = i[0];
      go(1'b0, {1'b0, w}, '0);
      chk(rdata, mk[w]);
      m = i < 2 ? '1 : rnd();
      x = i < 2 ? '1 : rnd();
      mk[w] = m;
      go(1'b1, {1'b0, w}, m);
      fire(w ? 32'h0 : x, w ? x : 32'h0);
      x &= w ? MEIU_STATUS_B_IMPL & 32'hffff_7fff : MEIU_STATUS_A_IMPL;
      chk(w ? ln_b : ln_a, want(x, m));
      go(1'b0, {1'b1, w}, '0);
      chk(rdata, x);
      pm = w ? MEIU_B_PHASE_PAIRED : MEIU_A_SIGN_PAIRED;
      chk(pend, x & pm);
      go(1'b1, {1'b1, w}, x & 32'h00ff_00ff);
      go(1'b0, {1'b1, w}, '0);
      chk(rdata, x & 32'hff00_ff00);
      chk(w ? ln_b : ln_a, want(x & 32'hff00_ff00, m));
      go(1'b1, {1'b1, w}, '1);
      chk(w ? ln_b : ln_a, 1'b1);
    end
    x = rnd();
    idle_in <= x[8:0];
    fire(32'h0, 32'h0001_0007);
    chk(idle_q, x[8:0]);
    tb_req <= '{1'b1, 1'b0, MEIU_SEL_STATUS_B, 32'h0001_0000};
    ev_b <= 32'h0001_0000;
    @(posedge sys_clk);
    tb_req <= '0;
    ev_b <= '0;
    @(posedge sys_clk);
    go(1'b0, MEIU_SEL_STATUS_B, '0);
    chk(rdata, 32'h0001_0007);
    chk(pend, 32'h0001_0007);
    go(1'b1, MEIU_SEL_MASK_B, 32'h0080_0000);
    host_en <= 1'b1;
    fire(32'h0, 32'h0080_0000);
    chk(ln_b, 1'b0);
    for (int k = 0; k < 9 && !ln_b; k++) @(posedge sys_clk);
    go(1'b0, MEIU_SEL_STATUS_B, '0);
    chk(ln_b, 1'b1);
    chk(rdata, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
